// [tb/cnmd_adc_model.sv]
// Behavioural converter that feeds samples into the mixer
`timescale 1ns/1ps
module cnmd_adc_model (
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    input  wire logic [cnmd_pkg::SMP_W-1:0]  level,
    output logic      [cnmd_pkg::SMP_W-1:0]  sample_out
);
    import cnmd_pkg::*;
    // Output register: new sample just after each edge, never mid-cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sample_out <= '0;
        end else begin
            sample_out <= level;
        end
    end
endmodule : cnmd_adc_model

// [tb/cnmd_top_asserts.sv]
// Port-level checker for the chirp mixer decimator, bound to its top module
`timescale 1ns/1ps
module cnmd_checker (
    input wire logic                              sys_clk,
    input wire logic                              nrst,
    input wire logic        [cnmd_pkg::ADR_W-1:0] reg_addr,
    input wire logic        [31:0]                reg_wdata,
    input wire logic                              reg_wr,
    input wire logic                              reg_rd,
    input wire logic        [31:0]                reg_rdata,
    input wire logic signed [cnmd_pkg::MIX_W-1:0] i_out,
    input wire logic signed [cnmd_pkg::MIX_W-1:0] q_out,
    input wire logic                              iq_valid
);
    import cnmd_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [1:0]  mode_reg;
    logic [31:0] mini_reg;
    logic [31:0] maxi_reg;
    logic [14:0] pre_reg;
    logic [2:0]  age_reg;
    logic        cw_q;
    logic        ch_q;
    // Shadow copies of what software wrote, so timing can be judged at the ports
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= 2'h0;
            mini_reg <= 32'h0;
            maxi_reg <= 32'h0;
            pre_reg  <= PRE_RST;
            age_reg  <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == ADR_CTRL) mode_reg <= reg_wdata[1:0];
            if (reg_wr && reg_addr == ADR_MINI) mini_reg <= reg_wdata;
            if (reg_wr && reg_addr == ADR_MAXI) maxi_reg <= reg_wdata;
            if (reg_wr && reg_addr == ADR_PRE) pre_reg <= reg_wdata[20:6];
            age_reg <= reg_wr ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
        end
    end
    logic [14:0] gap_reg;
    logic [1:0]  dirty_reg;
    logic        armed_reg;
    logic [7:0]  since_reg;
    // Spacing is only judged once an old preload can no longer be in flight
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gap_reg   <= 15'h0;
            dirty_reg <= 2'h0;
            armed_reg <= 1'b0;
            since_reg <= 8'h0;
        end else begin
            gap_reg   <= iq_valid ? 15'h0 : gap_reg + 15'h1;
            armed_reg <= armed_reg | iq_valid;
            since_reg <= (since_reg == 8'hFF) ? since_reg : since_reg + 8'h1;
            if (reg_wr && reg_addr == ADR_PRE) dirty_reg <= 2'h2;
            else if (iq_valid && dirty_reg != 2'h0) dirty_reg <= dirty_reg - 2'h1;
        end
    end
    assign cw_q = (mode_reg == MODE_CW) && (age_reg >= 3'h3);
    assign ch_q = (mode_reg != MODE_CW) && (age_reg >= 3'h3);
    sequence s_two_stat;
        reg_rd && reg_addr == ADR_PSTAT && cw_q && mini_reg[14:0] == 15'h0 ##1
        reg_rd && reg_addr == ADR_PSTAT;
    endsequence
    a_valid_pulse:
        assert property (iq_valid |=> !iq_valid) else $error("valid strobe longer than one clock");
    a_out_hold:
        assert property (!iq_valid |-> $stable(i_out) && $stable(q_out))
        else $error("outputs changed without strobe");
    a_valid_spacing:
        assert property (iq_valid && armed_reg && dirty_reg == 2'h0 |-> gap_reg == pre_reg)
        else $error("output spacing differs from preload plus one");
    a_no_early_out:
        assert property (iq_valid |-> since_reg >= 8'd20) else $error("output before filter filled");
    a_delta_width:
        assert property (reg_rd && reg_addr == ADR_DLTI |=> reg_rdata[31:24] == 8'h0)
        else $error("delta wider than 24 bits");
    a_cw_incr:
        assert property (reg_rd && reg_addr == ADR_ISTAT && cw_q |=> reg_rdata == mini_reg)
        else $error("continuous wave step is not the minimum increment");
    a_cw_phase_step:
        assert property (s_two_stat |=> 18'($past(reg_rdata[17:0]) - reg_rdata[17:0])
                         == {1'b0, mini_reg[31:15]})
        else $error("phase word step wrong");
    a_incr_bounds:
        assert property (reg_rd && reg_addr == ADR_ISTAT && ch_q |=> reg_rdata >= mini_reg &&
                         (reg_rdata < maxi_reg || (mode_reg == MODE_DOWN && reg_rdata == maxi_reg)))
        else $error("increment outside its limits");
endmodule : cnmd_checker

bind cnmd_top cnmd_checker CHK (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .i_out(i_out), .q_out(q_out), .iq_valid(iq_valid));

// [tb/cnmd_top_tb.sv]
// Self-checking bench for the chirp mixer decimator
`timescale 1ns/1ps
module cnmd_top_tb;
    import cnmd_pkg::*;
    logic                    sys_clk = 1'b0;
    logic                    nrst = 1'b0;
    logic        [ADR_W-1:0] reg_addr = '0;
    logic        [31:0]      reg_wdata = '0;
    logic                    reg_wr = 1'b0;
    logic                    reg_rd = 1'b0;
    logic        [31:0]      reg_rdata;
    logic signed [MIX_W-1:0] i_out;
    logic signed [MIX_W-1:0] q_out;
    logic                    iq_valid;
    logic        [SMP_W-1:0] sample_in;
    logic        [SMP_W-1:0] level = '0;
    logic        [31:0]      rb [0:15];
    int                      mismatches = 0;
    int                      checks_done = 0;

    always #20 sys_clk = ~sys_clk;

    cnmd_adc_model ADC (.sys_clk(sys_clk), .nrst(nrst), .level(level), .sample_out(sample_in));
    cnmd_top DUT (.sys_clk(sys_clk), .nrst(nrst), .sample_in(sample_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .i_out(i_out), .q_out(q_out), .iq_valid(iq_valid));
    //////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic give_verdict;
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic do_reset;
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
    endtask : do_reset

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Back-to-back reads of one index; data of read k is taken the edge after it
    task automatic rd_burst(input logic [3:0] a, input int n);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        for (int k = 0; k < n + 1; k++) begin
            @(posedge sys_clk);
            if (k == n - 1) reg_rd <= 1'b0;
            if (k > 0) rb[k-1] = reg_rdata;
        end
    endtask : rd_burst

    // Bounded wait for n strobes; gap is the edge count before the last one
    task automatic get_iq(input int n, output logic signed [MIX_W-1:0] i, output int gap);
        int t;
        t = 0;
        gap = 0;
        repeat (n) begin
            gap = 0;
            do begin
                @(posedge sys_clk);
                gap++;
                t++;
            end while (iq_valid !== 1'b1 && t < 2000);
        end
        i = i_out;
        check(t < 2000 && q_out >= -4 && q_out <= 4, "no strobe or quadrature not near zero");
    endtask : get_iq
    //////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] rst_v [0:7];
        rst_v = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7C0, 32'h8000};
        for (int a = 0; a < 8; a++) begin
            rd_burst(a[3:0], 1);
            check(rb[0] === rst_v[a], "reset value");
        end
        wr(ADR_DLTI, 32'hFFFFFFFF);
        wr(ADR_MAXI, 32'hFFFFFFFF);
        wr(4'hC, 32'h12345678);
        rd_burst(ADR_DLTI, 1);
        check(rb[0] === 32'h00FFFFFF, "delta width");
        rd_burst(ADR_MAXI, 1);
        check(rb[0] === 32'hFFFFFFFF, "maximum increment width");
        rd_burst(4'hC, 1);
        check(rb[0] === 32'h0, "unmapped index not zero");
    endtask : t_regs

    task automatic t_cw;
        wr(ADR_MINI, 32'h00018000);
        wr(ADR_MAXI, 32'h0);
        wr(ADR_DLTI, 32'h1234);
        wr(ADR_POFS, 32'h10000);
        wr(ADR_CTRL, 32'h0);
        rd_burst(ADR_PSTAT, 6);
        check(18'(18'h10000 - rb[0][17:0]) <= 18'd9, "phase not from offset");
        for (int k = 0; k < 5; k++) begin
            check(18'(rb[k][17:0] - rb[k+1][17:0]) === 18'd3, "phase step");
        end
        rd_burst(ADR_ISTAT, 3);
        check(rb[2] === 32'h00018000, "cw increment");
    endtask : t_cw

    task automatic t_chirp(input logic [1:0] m);
        logic        rise;
        logic        fall;
        logic [31:0] d;
        rise = 1'b0;
        fall = 1'b0;
        wr(ADR_MINI, 32'h100);
        wr(ADR_MAXI, 32'h400);
        wr(ADR_DLTI, 32'h100);
        wr(ADR_CTRL, {30'h0, m});
        rd_burst(ADR_ISTAT, 12);
        for (int k = 0; k < 11; k++) begin
            d = rb[k+1] - rb[k];
            if (m == MODE_UP) begin
                check(rb[k+1] === (rb[k] >= 32'h300 ? 32'h100 : rb[k] + 32'h100), "up");
            end else if (m == MODE_DOWN) begin
                check(rb[k+1] === (rb[k] < 32'h200 ? 32'h400 : rb[k] - 32'h100), "down");
            end else begin
                check((d === 32'h100 || d === -32'h100 || rb[k+1] === 32'h100) &&
                      rb[k+1] < 32'h400 && rb[k+1] >= 32'h100, "up/down step");
                rise = rise | (d === 32'h100);
                fall = fall | (d === -32'h100);
            end
        end
        if (m == MODE_UPDOWN) check(rise && fall, "up/down never turned");
    endtask : t_chirp

    task automatic t_stream;
        logic signed [MIX_W-1:0] i1;
        logic signed [MIX_W-1:0] i2;
        int                      g;
        do_reset();
        check(i_out === 17'h0 && iq_valid === 1'b0, "outputs after reset");
        wr(ADR_PRE, 32'h0C0);
        wr(ADR_SHF, 32'h41);
        level <= 16'h4000;
        get_iq(12, i1, g);
        check(i1 > 0, "in-phase sign positive");
        check(g === 4, "output spacing");
        level <= 16'hC000;
        get_iq(12, i2, g);
        check(i2 < 0, "in-phase sign negative");
        wr(ADR_CTRL, 32'h4);
        get_iq(12, i2, g);
        check(i2 > 0, "offset binary input");
        wr(ADR_CTRL, 32'h0);
        level <= 16'h4000;
        wr(ADR_SCALE, 32'h4000);
        get_iq(12, i2, g);
        check(i2 - (i1 >>> 1) <= 1 && i2 - (i1 >>> 1) >= -1, "half scale");
    endtask : t_stream
    //////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        do_reset();
        t_regs();
        t_cw();
        t_chirp(MODE_UP);
        t_chirp(MODE_DOWN);
        t_chirp(MODE_UPDOWN);
        t_stream();
        give_verdict();
    end
endmodule : cnmd_top_tb

// [verilog/cnmd_cascade.sv]
// Five-stage decimating integrator/comb filter for one real branch
`timescale 1ns/1ps
module cnmd_cascade (
    input  wire logic                              sys_clk,
    input  wire logic                              nrst,
    input  wire logic signed [cnmd_pkg::MIX_W-1:0] din,
    input  wire logic        [cnmd_pkg::SHF_W-1:0] shift,
    input  wire logic                              dec_stb,
    output logic signed      [cnmd_pkg::FLT_W-1:0] dout,
    output logic                                   dout_vld
);
    import cnmd_pkg::*;

    localparam int W_LAST = CIC_W - (2 * STAGES - 1) * CIC_DRP;

    logic signed [CIC_W-1:0] din_sh;
    logic [2:0]              fill_reg;
    logic                    stb_d_reg;

    assign din_sh = CIC_W'(din) <<< shift;

    //////////////////////////////////////////////////////////////////////////
    // Integrators, each dropping low bits of the one before
    for (genvar k = 0; k < STAGES; k++) begin : integ
        localparam int WK = CIC_W - k * CIC_DRP;
        logic signed [WK-1:0] acc;
        logic signed [WK-1:0] src;
        if (k == 0) begin : g_first
            assign src = din_sh;
        end else begin : g_next
            assign src = integ[k-1].acc[WK+CIC_DRP-1 -: WK];
        end
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) acc <= '0;
            else       acc <= acc + src;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Combs at the decimated rate
    for (genvar j = 0; j < STAGES; j++) begin : comb
        localparam int WC = CIC_W - (STAGES + j) * CIC_DRP;
        logic signed [WC-1:0] dly;
        logic signed [WC-1:0] res;
        logic signed [WC-1:0] src;
        if (j == 0) begin : g_first
            assign src = integ[STAGES-1].acc[WC+CIC_DRP-1 -: WC];
        end else begin : g_next
            assign src = comb[j-1].res[WC+CIC_DRP-1 -: WC];
        end
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                dly <= '0;
                res <= '0;
            end else if (dec_stb) begin
                res <= src - dly;
                dly <= src;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Hold off output until the pipeline holds only post-reset samples
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fill_reg  <= 3'h0;
            stb_d_reg <= 1'b0;
            dout      <= '0;
            dout_vld  <= 1'b0;
        end else begin
            stb_d_reg <= dec_stb;
            dout_vld  <= 1'b0;
            if (dec_stb && fill_reg != 3'(FILL_N)) begin
                fill_reg <= fill_reg + 3'h1;
            end
            if (stb_d_reg && fill_reg == 3'(FILL_N)) begin
                dout     <= comb[STAGES-1].res[W_LAST-1 -: FLT_W];
                dout_vld <= 1'b1;
            end
        end
    end

endmodule : cnmd_cascade

// [verilog/cnmd_pkg.sv]
// Constants, types and field layouts of the chirp oscillator, mixer and decimator
//////////////////////////////////////////////////////////////////////////////////
package cnmd_pkg;

    localparam int SMP_W   = 16;
    localparam int MIX_W   = 17;
    localparam int PH_W    = 33;
    localparam int PW_W    = 18;
    localparam int INC_W   = 32;
    localparam int DLT_W   = 24;
    localparam int SHF_W   = 7;
    localparam int PRE_W   = 15;
    localparam int SCL_W   = 16;
    localparam int FLT_W   = 18;
    localparam int STAGES  = 5;
    localparam int CIC_W   = 92;
    localparam int CIC_DRP = 4;
    localparam int FILL_N  = 5;

    // Register indices on the plain register port
    localparam int ADR_W = 4;
    localparam logic [3:0] ADR_CTRL  = 4'h0;
    localparam logic [3:0] ADR_POFS  = 4'h1;
    localparam logic [3:0] ADR_MINI  = 4'h2;
    localparam logic [3:0] ADR_MAXI  = 4'h3;
    localparam logic [3:0] ADR_DLTI  = 4'h4;
    localparam logic [3:0] ADR_SHF   = 4'h5;
    localparam logic [3:0] ADR_PRE   = 4'h6;
    localparam logic [3:0] ADR_SCALE = 4'h7;
    localparam logic [3:0] ADR_PSTAT = 4'h8;
    localparam logic [3:0] ADR_ISTAT = 4'h9;

    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OBIN_BIT = 2;
    localparam int PRE_CNT_LSB   = 21;

    // Values after reset
    localparam logic [SHF_W-1:0] SHIFT_RST = 7'h00;
    localparam logic [PRE_W-1:0] PRE_RST   = 15'h001F;
    localparam logic [SCL_W-1:0] SCALE_RST = 16'h8000;

    typedef enum logic [1:0] {
        MODE_CW     = 2'b00,
        MODE_UP     = 2'b01,
        MODE_DOWN   = 2'b10,
        MODE_UPDOWN = 2'b11
    } cnmd_mode_t;

    typedef enum logic [1:0] {
        SWP_LOAD = 2'b00,
        SWP_RISE = 2'b01,
        SWP_FALL = 2'b10
    } cnmd_sweep_t;

endpackage : cnmd_pkg

// [verilog/cnmd_top.sv]
// Chirp phase generator, quadrature mixer, decimators and gain scaling
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module cnmd_top (
    input  wire logic                               sys_clk,
    input  wire logic                               nrst,
    input  wire logic        [cnmd_pkg::SMP_W-1:0]  sample_in,
    input  wire logic        [cnmd_pkg::ADR_W-1:0]  reg_addr,
    input  wire logic        [31:0]                 reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic             [31:0]                 reg_rdata,
    output logic signed      [cnmd_pkg::MIX_W-1:0]  i_out,
    output logic signed      [cnmd_pkg::MIX_W-1:0]  q_out,
    output logic                                    iq_valid
);
    import cnmd_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Declarations
    cnmd_mode_t              mode_reg;
    logic                    obin_reg;
    logic [PW_W-1:0]         pofs_reg;
    logic [INC_W-1:0]        mini_reg;
    logic [INC_W-1:0]        maxi_reg;
    logic [DLT_W-1:0]        dlti_reg;
    logic [SHF_W-1:0]        shift_reg;
    logic [PRE_W-1:0]        pre_reg;
    logic [SCL_W-1:0]        scale_reg;
    logic                    restart_reg;

    cnmd_sweep_t             sweep_reg;
    cnmd_sweep_t             sweep_next;
    logic [PH_W-1:0]         phase_reg;
    logic [PH_W-1:0]         phase_next;
    logic [INC_W-1:0]        incr_reg;
    logic [INC_W-1:0]        incr_next;
    logic [INC_W:0]          inc_up;
    logic [INC_W:0]          inc_dn;
    logic [PW_W-1:0]         phase_word;

    logic signed [MIX_W-1:0] cos_reg;
    logic signed [MIX_W-1:0] nsin_reg;
    logic signed [SMP_W-1:0] smp_reg;
    logic signed [MIX_W-1:0] mix_i_reg;
    logic signed [MIX_W-1:0] mix_q_reg;

    logic [PRE_W-1:0]        dec_cnt_reg;
    logic                    dec_stb;
    logic signed [FLT_W-1:0] flt_i;
    logic signed [FLT_W-1:0] flt_q;
    logic                    flt_i_vld;
    logic                    flt_q_vld;

    //////////////////////////////////////////////////////////////////////////
    // Helpers

    // Parabolic sine of a full-turn phase, magnitude kept below one
    function automatic logic signed [MIX_W-1:0] para_sin(input logic [PW_W-1:0] p);
        logic [16:0] u;
        logic [33:0] sq;
        logic [15:0] mag;
        u   = p[16:0];
        sq  = 34'(u) * 34'(17'h1FFFF - u);
        mag = sq[32:17];
        if (mag == 16'hFFFF) begin
            mag = 16'hFFFE;
        end
        para_sin = p[17] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction : para_sin

    // Round half away from zero, dropping the low n bits of a 34-bit value
    function automatic logic signed [33:0] sym_round(input logic signed [33:0] v,
                                                     input int n);
        logic signed [33:0] half;
        half = 34'sh1 <<< (n - 1);
        if (v < 0) begin
            sym_round = (v + half - 34'sh1) >>> n;
        end else begin
            sym_round = (v + half) >>> n;
        end
    endfunction : sym_round

    // Clamp to the signed 17-bit range
    function automatic logic signed [MIX_W-1:0] sat17(input logic signed [33:0] v);
        if (v > 34'sh0FFFF) begin
            sat17 = 17'h0FFFF;
        end else if (v < -34'sh10000) begin
            sat17 = 17'h10000;
        end else begin
            sat17 = v[MIX_W-1:0];
        end
    endfunction : sat17

    //////////////////////////////////////////////////////////////////////////
    // Register port
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg    <= MODE_CW;
            obin_reg    <= 1'b0;
            pofs_reg    <= '0;
            mini_reg    <= '0;
            maxi_reg    <= '0;
            dlti_reg    <= '0;
            shift_reg   <= SHIFT_RST;
            pre_reg     <= PRE_RST;
            scale_reg   <= SCALE_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                ADR_CTRL: begin
                    mode_reg <= cnmd_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
                    obin_reg <= reg_wdata[CTRL_OBIN_BIT];
                end
                ADR_POFS:  pofs_reg  <= reg_wdata[PW_W-1:0];
                ADR_MINI:  mini_reg  <= reg_wdata;
                ADR_MAXI:  maxi_reg  <= reg_wdata;
                ADR_DLTI:  dlti_reg  <= reg_wdata[DLT_W-1:0];
                ADR_SHF:   shift_reg <= reg_wdata[SHF_W-1:0];
                ADR_PRE:   pre_reg   <= reg_wdata[PRE_CNT_LSB-15 +: PRE_W];
                ADR_SCALE: scale_reg <= reg_wdata[SCL_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Phase setup writes restart the sweep from the offset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            restart_reg <= 1'b1;
        end else begin
            restart_reg <= reg_wr && (reg_addr == ADR_CTRL || reg_addr == ADR_POFS
                                      || reg_addr == ADR_MINI || reg_addr == ADR_MAXI);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                ADR_CTRL:  reg_rdata <= {29'h0, obin_reg, mode_reg};
                ADR_POFS:  reg_rdata <= {14'h0, pofs_reg};
                ADR_MINI:  reg_rdata <= mini_reg;
                ADR_MAXI:  reg_rdata <= maxi_reg;
                ADR_DLTI:  reg_rdata <= {8'h0, dlti_reg};
                ADR_SHF:   reg_rdata <= {25'h0, shift_reg};
                ADR_PRE:   reg_rdata <= {11'h0, pre_reg, 6'h0};
                ADR_SCALE: reg_rdata <= {16'h0, scale_reg};
                ADR_PSTAT: reg_rdata <= {12'h0, sweep_reg, phase_word};
                ADR_ISTAT: reg_rdata <= incr_reg;
                default:   reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Phase generator
    // Full-width add keeps the sweep monotonic when the low 24 bits carry
    assign inc_up = {1'b0, incr_reg} + {9'h0, dlti_reg};
    assign inc_dn = {1'b0, incr_reg} - {9'h0, dlti_reg};

    always_comb begin
        sweep_next = sweep_reg;
        incr_next  = incr_reg;
        phase_next = {1'b0, phase_reg[INC_W-1:0]} - {1'b0, incr_reg};
        if (restart_reg || sweep_reg == SWP_LOAD) begin
            phase_next = {pofs_reg, 15'h0};
            sweep_next = SWP_RISE;
            case (mode_reg)
                MODE_DOWN: begin
                    incr_next  = maxi_reg;
                    sweep_next = SWP_FALL;
                end
                default: incr_next = mini_reg;
            endcase
        end else begin
            case (mode_reg)
                MODE_CW: incr_next = mini_reg;
                MODE_UP: begin
                    if (inc_up >= {1'b0, maxi_reg}) incr_next = mini_reg;
                    else                            incr_next = inc_up[INC_W-1:0];
                end
                MODE_DOWN: begin
                    if (inc_dn[INC_W] || inc_dn < {1'b0, mini_reg}) begin
                        incr_next = maxi_reg;
                    end else begin
                        incr_next = inc_dn[INC_W-1:0];
                    end
                end
                MODE_UPDOWN: begin
                    if (sweep_reg == SWP_RISE) begin
                        if (inc_up >= {1'b0, maxi_reg}) begin
                            sweep_next = SWP_FALL;
                            incr_next  = inc_dn[INC_W] ? mini_reg : inc_dn[INC_W-1:0];
                        end else begin
                            incr_next = inc_up[INC_W-1:0];
                        end
                    end else if (inc_dn[INC_W] || inc_dn < {1'b0, mini_reg}) begin
                        sweep_next = SWP_RISE;
                        incr_next  = mini_reg;
                    end else begin
                        incr_next = inc_dn[INC_W-1:0];
                    end
                end
                default: incr_next = mini_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sweep_reg <= SWP_LOAD;
            phase_reg <= '0;
            incr_reg  <= '0;
        end else begin
            sweep_reg <= sweep_next;
            phase_reg <= phase_next;
            incr_reg  <= incr_next;
        end
    end

    assign phase_word = phase_reg[PH_W-1 -: PW_W];

    //////////////////////////////////////////////////////////////////////////
    // Oscillator and mixer
    // Phase already runs downward, so plain cos/-sin of it turns counterclockwise
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cos_reg  <= '0;
            nsin_reg <= '0;
            smp_reg  <= '0;
        end else begin
            cos_reg  <= para_sin(phase_word + 18'h10000);
            nsin_reg <= -para_sin(phase_word);
            smp_reg  <= obin_reg ? $signed({~sample_in[SMP_W-1], sample_in[SMP_W-2:0]})
                                 : $signed(sample_in);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mix_i_reg <= '0;
            mix_q_reg <= '0;
        end else begin
            mix_i_reg <= sat17(sym_round(34'(smp_reg) * 34'(cos_reg), 16));
            mix_q_reg <= sat17(sym_round(34'(smp_reg) * 34'(nsin_reg), 16));
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Decimation counter shared by both branches
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dec_cnt_reg <= '0;
        end else if (dec_cnt_reg == '0) begin
            dec_cnt_reg <= pre_reg;
        end else begin
            dec_cnt_reg <= dec_cnt_reg - 15'h0001;
        end
    end

    assign dec_stb = (dec_cnt_reg == '0);

    cnmd_cascade u_flt_i (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .din      (mix_i_reg),
        .shift    (shift_reg),
        .dec_stb  (dec_stb),
        .dout     (flt_i),
        .dout_vld (flt_i_vld)
    );

    cnmd_cascade u_flt_q (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .din      (mix_q_reg),
        .shift    (shift_reg),
        .dec_stb  (dec_stb),
        .dout     (flt_q),
        .dout_vld (flt_q_vld)
    );

    //////////////////////////////////////////////////////////////////////////
    // Gain scaling; 1.17 by 1.15 gives 2.32, rounded half away from zero to 1.16
    // Products near two are clamped rather than wrapped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            i_out    <= '0;
            q_out    <= '0;
            iq_valid <= 1'b0;
        end else begin
            iq_valid <= flt_i_vld && flt_q_vld;
            if (flt_i_vld) begin
                i_out <= sat17(sym_round(34'(flt_i) * $signed({18'h0, scale_reg}), 16));
                q_out <= sat17(sym_round(34'(flt_q) * $signed({18'h0, scale_reg}), 16));
            end
        end
    end

endmodule : cnmd_top
